// file: ilr_pkg.sv
// Package for the identification and input limit register slice.
// Assumes a byte-wide register port with single-cycle strobes.
`default_nettype none
package ilr_pkg;
	// ****************************************
	// Offsets
	// ****************************************
	localparam logic [7:0] ILR_OFS_ID = 8'h00;
	localparam logic [7:0] ILR_OFS_REV = 8'h01;
	localparam logic [7:0] ILR_OFS_LIMIT = 8'h02;
	// ****************************************
	// Field positions
	// ****************************************
	localparam int ILR_MAKER_LSB = 4;
	localparam int ILR_ADAPT_LSB = 5;
	localparam int ILR_SYSRAIL_BIT = 3;
	localparam int ILR_INPUT_CURRENT_LIMIT_SEL_LSB = 0;
	// ****************************************
	// Identity values (arbitrary neutral values)
	// ****************************************
	localparam logic [3:0] ILR_MAKER_CODE = 4'h5; // Arbitrary value
	localparam logic [3:0] ILR_PART_CODE = 4'h3; // Arbitrary value
	localparam logic [3:0] ILR_REV_CODE = 4'h2; // Arbitrary value
	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [2:0] ILR_ADAPT_RST = 3'h4;
	localparam logic ILR_SYSRAIL_RST = 1'b0;
	localparam logic [2:0] ILR_INPUT_CURRENT_LIMIT_SEL_RST = 3'h1;
	localparam logic [15:0] ILR_ADAPT_MV_RST = 16'h11f8; // 4.6 V, decode of the reset code
	localparam logic [15:0] ILR_INPUT_CURRENT_LIMIT_SEL_MA_RST = 16'h0064; // 100 mA, decode of the reset code
	localparam logic [2:0] ILR_ADAPT_MIN_VALID = 3'h2;
endpackage : ilr_pkg
`default_nettype wire

// file: ilr_decode.sv
// Decoder from selector codes to physical settings.
// Assumes codes come straight from the configuration register.
`default_nettype none
module ilr_decode (
	input wire logic [2:0] adaptSel, // Adaptive threshold code
	input wire logic [2:0] ilimSel, // Current limit code
	output logic [15:0] adaptMv, // Threshold in mV, zero if undefined
	output logic [15:0] ilimMa // Current limit in mA
);
	import ilr_pkg::*;
	// Threshold: 4.4 V at code 2, 100 mV a step
	always_comb begin
		if (adaptSel >= ILR_ADAPT_MIN_VALID) begin
			adaptMv = 16'(4200 + 100 * int'(adaptSel));
		end else begin
			adaptMv = 16'h0000; // Undefined codes give no threshold
		end
	end
	// Current: 50 mA steps up to code 5, then two coarse steps
	always_comb begin
		case (ilimSel)
			3'h6: ilimMa = 16'd400;
			3'h7: ilimMa = 16'd500;
			default: ilimMa = 16'(50 + 50 * int'(ilimSel));
		endcase
	end
endmodule : ilr_decode
`default_nettype wire

// file: ilr_regs.sv
// Register slice: identification, revision and input limit configuration.
// Assumes a master that strobes one cycle at a time and never waits.
`default_nettype none
module ilr_regs (
	input wire logic clk, // 100 MHz clock
	input wire logic resetn, // Synchronous reset, active low
	input wire logic [7:0] regAddr, // Register offset
	input wire logic [7:0] regWdata, // Write data
	input wire logic regWrite, // Write strobe
	input wire logic regRead, // Read strobe
	output logic [7:0] regRdata, // Read data, one cycle after strobe
	output logic [2:0] adaptive_limit_threshold_sel, // Threshold code
	output logic system_rail_target_sel, // 0: termination + 200 mV, 1: 5 V
	output logic [2:0] input_current_limit_sel, // Current limit code
	output logic [15:0] adaptThresholdMv, // Decoded threshold
	output logic [15:0] inputLimitMa // Decoded current limit
);
	import ilr_pkg::*;

	logic [15:0] next_adaptMv;
	logic [15:0] next_ilimMa;
	logic [7:0] next_rdata;

	// ****************************************
	// Address decode
	// ****************************************
	// True when a strobe targets the configuration register
	function automatic logic hits_limit(input logic [7:0] addr);
		return addr == ILR_OFS_LIMIT;
	endfunction : hits_limit

	// ****************************************
	// Configuration register
	// ****************************************
	// Offsets 0 and 1 have no storage, so writes there simply vanish
	always_ff @(posedge clk) begin
		if (!resetn) begin
			adaptive_limit_threshold_sel <= ILR_ADAPT_RST;
			system_rail_target_sel <= ILR_SYSRAIL_RST;
			input_current_limit_sel <= ILR_INPUT_CURRENT_LIMIT_SEL_RST;
		end else if (regWrite && hits_limit(regAddr)) begin
			adaptive_limit_threshold_sel <= regWdata[ILR_ADAPT_LSB +: 3];
			system_rail_target_sel <= regWdata[ILR_SYSRAIL_BIT];
			input_current_limit_sel <= regWdata[ILR_INPUT_CURRENT_LIMIT_SEL_LSB +: 3];
		end
	end

	// ****************************************
	// Read path
	// ****************************************
	// Unmapped offsets and reserved bits read zero
	always_comb begin
		next_rdata = 8'h00;
		case (regAddr)
			ILR_OFS_ID: begin
				next_rdata[ILR_MAKER_LSB +: 4] = ILR_MAKER_CODE;
				next_rdata[3:0] = ILR_PART_CODE;
			end
			ILR_OFS_REV: next_rdata[3:0] = ILR_REV_CODE;
			ILR_OFS_LIMIT: begin
				next_rdata[ILR_ADAPT_LSB +: 3] = adaptive_limit_threshold_sel;
				next_rdata[ILR_SYSRAIL_BIT] = system_rail_target_sel;
				next_rdata[ILR_INPUT_CURRENT_LIMIT_SEL_LSB +: 3] = input_current_limit_sel;
			end
			default: next_rdata = 8'h00;
		endcase
	end

	// Data is valid only in the cycle after the strobe, zero otherwise
	always_ff @(posedge clk) begin
		if (!resetn) begin
			regRdata <= 8'h00;
		end else if (regRead) begin
			regRdata <= next_rdata;
		end else begin
			regRdata <= 8'h00;
		end
	end

	// ****************************************
	// Decoded settings
	// ****************************************
	ilr_decode u_decode (
		.adaptSel(adaptive_limit_threshold_sel),
		.ilimSel(input_current_limit_sel),
		.adaptMv(next_adaptMv),
		.ilimMa(next_ilimMa)
	);

	// Registered so outputs come from flip-flops; lags the selector by one cycle
	always_ff @(posedge clk) begin
		if (!resetn) begin
			adaptThresholdMv <= ILR_ADAPT_MV_RST;
			inputLimitMa <= ILR_INPUT_CURRENT_LIMIT_SEL_MA_RST;
		end else begin
			adaptThresholdMv <= next_adaptMv;
			inputLimitMa <= next_ilimMa;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	// Steps of a register access, shared by the checks below
	sequence s_limit_write;
		regWrite && regAddr == ILR_OFS_LIMIT;
	endsequence
	sequence s_limit_read;
		regRead && regAddr == ILR_OFS_LIMIT;
	endsequence
	sequence s_unmapped_read;
		regRead && regAddr > ILR_OFS_LIMIT;
	endsequence
	// Write followed at once by a read of the same register
	sequence s_write_then_read;
		s_limit_write ##1 s_limit_read;
	endsequence

	// Fixed identification and revision reads
	a_id_read_fixed: assert property (@(posedge clk) disable iff (!resetn)
		regRead && regAddr == ILR_OFS_ID |=> regRdata[7:4] == ILR_MAKER_CODE)
		else $error("maker code wrong");
	a_part_read_fixed: assert property (@(posedge clk) disable iff (!resetn)
		regRead && regAddr == ILR_OFS_ID |=> regRdata[3:0] == ILR_PART_CODE)
		else $error("part code wrong");
	a_rev_read_fixed: assert property (@(posedge clk) disable iff (!resetn)
		regRead && regAddr == ILR_OFS_REV |=> regRdata == {4'h0, ILR_REV_CODE})
		else $error("revision read wrong");
	// No register behind these offsets, so nothing but zero may come back
	a_unmapped_read_zero: assert property (@(posedge clk) disable iff (!resetn)
		s_unmapped_read |=> regRdata == 8'h00)
		else $error("unmapped read not zero");

	// Writes land in the cycle after the strobe
	a_adapt_write_lands: assert property (@(posedge clk) disable iff (!resetn)
		regWrite && regAddr == ILR_OFS_LIMIT
		|=> adaptive_limit_threshold_sel == $past(regWdata[7:5]))
		else $error("threshold write lost");
	a_adapt_decode_ok: assert property (@(posedge clk) disable iff (!resetn)
		$past(adaptive_limit_threshold_sel) == 3'h7 |-> adaptThresholdMv == 16'd4900)
		else $error("threshold decode wrong");
	a_input_current_limit_sel_write_lands: assert property (@(posedge clk) disable iff (!resetn)
		regWrite && regAddr == ILR_OFS_LIMIT
		|=> input_current_limit_sel == $past(regWdata[2:0]))
		else $error("current write lost");
	a_input_current_limit_sel_decode_ok: assert property (@(posedge clk) disable iff (!resetn)
		$past(input_current_limit_sel) == 3'h6 |-> inputLimitMa == 16'd400)
		else $error("current decode wrong");
	a_rail_readback_ok: assert property (@(posedge clk) disable iff (!resetn)
		s_write_then_read
		|=> regRdata[ILR_SYSRAIL_BIT] == $past(regWdata[ILR_SYSRAIL_BIT], 2)
			&& regRdata[4] == 1'b0)
		else $error("rail readback wrong");
	// Rail selector follows the written bit
	a_rail_write_lands: assert property (@(posedge clk) disable iff (!resetn)
		s_limit_write |=> system_rail_target_sel == $past(regWdata[ILR_SYSRAIL_BIT]))
		else $error("rail write lost");
	// Readback packs the fields around the reserved bit, which always reads zero
	a_limit_readback: assert property (@(posedge clk) disable iff (!resetn)
		s_limit_read |=> regRdata == {$past(adaptive_limit_threshold_sel), 1'b0,
			$past(system_rail_target_sel), $past(input_current_limit_sel)})
		else $error("limit readback wrong");
	// Writes to the identification offsets must leave the configuration alone
	a_ro_write_ignored: assert property (@(posedge clk) disable iff (!resetn)
		regWrite && regAddr != ILR_OFS_LIMIT
		|=> $stable(adaptive_limit_threshold_sel) && $stable(system_rail_target_sel)
			&& $stable(input_current_limit_sel))
		else $error("read-only write changed config");
	// Without a write, nothing moves the configuration
	a_config_holds: assert property (@(posedge clk) disable iff (!resetn)
		!regWrite
		|=> $stable(adaptive_limit_threshold_sel) && $stable(system_rail_target_sel)
			&& $stable(input_current_limit_sel))
		else $error("config changed without write");
	// First edge out of reset shows every reset value, decoded outputs included
	a_reset_values: assert property (@(posedge clk) disable iff (!resetn)
		!$past(resetn)
		|-> adaptive_limit_threshold_sel == ILR_ADAPT_RST
			&& system_rail_target_sel == ILR_SYSRAIL_RST
			&& input_current_limit_sel == ILR_INPUT_CURRENT_LIMIT_SEL_RST && regRdata == 8'h00
			&& adaptThresholdMv == ILR_ADAPT_MV_RST && inputLimitMa == ILR_INPUT_CURRENT_LIMIT_SEL_MA_RST)
		else $error("reset values wrong");

	// Threshold table: codes 0 and 1 have no threshold, then 4.4 V up in 100 mV steps
	a_adapt_undef_zero: assert property (@(posedge clk) disable iff (!resetn)
		$past(adaptive_limit_threshold_sel) < ILR_ADAPT_MIN_VALID |-> adaptThresholdMv == 16'h0000)
		else $error("undefined threshold not zero");
	a_adapt_code2_ok: assert property (@(posedge clk) disable iff (!resetn)
		$past(adaptive_limit_threshold_sel) == 3'h2 |-> adaptThresholdMv == 16'h1130)
		else $error("threshold 4.4 V wrong");
	a_adapt_code3_ok: assert property (@(posedge clk) disable iff (!resetn)
		$past(adaptive_limit_threshold_sel) == 3'h3 |-> adaptThresholdMv == 16'h1194)
		else $error("threshold 4.5 V wrong");
	a_adapt_code4_ok: assert property (@(posedge clk) disable iff (!resetn)
		$past(adaptive_limit_threshold_sel) == 3'h4 |-> adaptThresholdMv == 16'h11f8)
		else $error("threshold 4.6 V wrong");
	a_adapt_code5_ok: assert property (@(posedge clk) disable iff (!resetn)
		$past(adaptive_limit_threshold_sel) == 3'h5 |-> adaptThresholdMv == 16'h125c)
		else $error("threshold 4.7 V wrong");
	a_adapt_code6_ok: assert property (@(posedge clk) disable iff (!resetn)
		$past(adaptive_limit_threshold_sel) == 3'h6 |-> adaptThresholdMv == 16'h12c0)
		else $error("threshold 4.8 V wrong");

	// Current table: 50 mA steps from code 0 to code 5
	a_input_current_limit_sel_code0_ok: assert property (@(posedge clk) disable iff (!resetn)
		$past(input_current_limit_sel) == 3'h0 |-> inputLimitMa == 16'h0032)
		else $error("current 50 mA wrong");
	a_input_current_limit_sel_code1_ok: assert property (@(posedge clk) disable iff (!resetn)
		$past(input_current_limit_sel) == 3'h1 |-> inputLimitMa == 16'h0064)
		else $error("current 100 mA wrong");
	a_input_current_limit_sel_code2_ok: assert property (@(posedge clk) disable iff (!resetn)
		$past(input_current_limit_sel) == 3'h2 |-> inputLimitMa == 16'h0096)
		else $error("current 150 mA wrong");
	a_input_current_limit_sel_code3_ok: assert property (@(posedge clk) disable iff (!resetn)
		$past(input_current_limit_sel) == 3'h3 |-> inputLimitMa == 16'h00c8)
		else $error("current 200 mA wrong");
	a_input_current_limit_sel_code4_ok: assert property (@(posedge clk) disable iff (!resetn)
		$past(input_current_limit_sel) == 3'h4 |-> inputLimitMa == 16'h00fa)
		else $error("current 250 mA wrong");
	a_input_current_limit_sel_code5_ok: assert property (@(posedge clk) disable iff (!resetn)
		$past(input_current_limit_sel) == 3'h5 |-> inputLimitMa == 16'h012c)
		else $error("current 300 mA wrong");

	// Top code jumps to 500 mA, past the linear run
	a_input_current_limit_sel_code7_ok: assert property (@(posedge clk) disable iff (!resetn)
		$past(input_current_limit_sel) == 3'h7 |-> inputLimitMa == 16'h01f4)
		else $error("current 500 mA wrong");
endmodule : ilr_regs
`default_nettype wire

// file: id_and_input_limit_regs_test.sv
// Self-checking bench for the identification and input limit register slice.
// Assumes ilr_pkg and ilr_regs are compiled first; one 100 MHz clock domain.
`default_nettype none
module id_and_input_limit_regs_test;
	timeunit 1ns;
	timeprecision 1ps;
	import ilr_pkg::*;
	// ****************************************
	// Stimulus and observed signals
	// ****************************************
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] regAddr = 8'h00;
	logic [7:0] regWdata = 8'h00;
	logic regWrite = 1'b0;
	logic regRead = 1'b0;
	logic [7:0] regRdata;
	logic [2:0] adaptSel;
	logic sysSel;
	logic [2:0] ilimSel;
	logic [15:0] adaptMv;
	logic [15:0] ilimMa;
	logic [7:0] rdData;
	int errors = 0;
	int check_count = 0;
	// Expected settings for codes 0..7: threshold in mV (zero for codes 0 and 1, then 4.4 V to 4.9 V), current in mA
	logic [15:0] adaptTable [8] = '{16'h0000, 16'h0000, 16'h1130, 16'h1194,
		16'h11f8, 16'h125c, 16'h12c0, 16'h1324};
	logic [15:0] ilimTable [8] = '{16'h0032, 16'h0064, 16'h0096, 16'h00c8,
		16'h00fa, 16'h012c, 16'h0190, 16'h01f4};
	// Free-running clock
	always #5 clk = ~clk;
	ilr_regs i_dut (.clk(clk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
		.regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
		.adaptive_limit_threshold_sel(adaptSel), .system_rail_target_sel(sysSel),
		.input_current_limit_sel(ilimSel), .adaptThresholdMv(adaptMv), .inputLimitMa(ilimMa));
	// ****************************************
	// Bus and compare helpers
	// ****************************************
	task cmp(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : cmp
	// One-cycle write strobe
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge clk);
		regWrite <= 1'b0;
	endtask : wr
	// Read data stands only in the cycle after the strobe
	task rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clk);
		regRead <= 1'b0;
		#1 d = regRdata;
	endtask : rd
	// ****************************************
	// Scenarios
	// ****************************************
	task test_reset();
		rd(ILR_OFS_LIMIT, rdData);
		cmp(rdData, 8'h81);
		cmp({adaptSel, sysSel, ilimSel}, 7'h41);
		cmp(adaptMv, 16'd4600);
		cmp(ilimMa, 16'd100);
		$display("test_reset done");
	endtask : test_reset
	// Writes to read-only and unmapped places must change nothing
	task test_ident();
		wr(ILR_OFS_ID, 8'hff);
		wr(ILR_OFS_REV, 8'hff);
		wr(8'h7f, 8'h00);
		rd(ILR_OFS_ID, rdData);
		cmp(rdData, {ILR_MAKER_CODE, ILR_PART_CODE});
		rd(ILR_OFS_REV, rdData);
		cmp(rdData, {4'h0, ILR_REV_CODE});
		rd(8'h7f, rdData);
		cmp(rdData, 8'h00);
		rd(ILR_OFS_LIMIT, rdData);
		cmp(rdData, 8'h81);
		$display("test_ident done");
	endtask : test_ident
	// Every selector code, reserved bit 4 written high
	task test_codes();
		for (int c = 0; c < 8; c++) begin
			wr(ILR_OFS_LIMIT, {c[2:0], 1'b1, c[0], c[2:0]});
			#1 cmp({adaptSel, sysSel, ilimSel}, {c[2:0], c[0], c[2:0]});
			@(posedge clk);
			#1 cmp(adaptMv, adaptTable[c]);
			cmp(ilimMa, ilimTable[c]);
			rd(ILR_OFS_LIMIT, rdData);
			cmp(rdData, {c[2:0], 1'b0, c[0], c[2:0]});
		end
		$display("test_codes done");
	endtask : test_codes
	// Strobes with no gap: write, read of the new value, read of the id, then idle
	task test_back_to_back();
		@(posedge clk);
		regAddr <= ILR_OFS_LIMIT;
		regWdata <= 8'hbe;
		regWrite <= 1'b1;
		@(posedge clk);
		regWrite <= 1'b0;
		regRead <= 1'b1;
		@(posedge clk);
		regAddr <= ILR_OFS_ID;
		#1 cmp(regRdata, 8'hae);
		cmp({adaptSel, sysSel, ilimSel}, 7'h5e);
		@(posedge clk);
		regRead <= 1'b0;
		#1 cmp(regRdata, {ILR_MAKER_CODE, ILR_PART_CODE});
		@(posedge clk);
		#1 cmp(regRdata, 8'h00);
		$display("test_back_to_back done");
	endtask : test_back_to_back
	task end_of_test();
		$display("checks %0d, mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : end_of_test
	// Main sequence: reset for 6 cycles, then the scenarios
	initial begin
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		test_reset();
		test_ident();
		test_codes();
		test_back_to_back();
		end_of_test();
	end
endmodule : id_and_input_limit_regs_test
`default_nettype wire
